// ---- fbcwd_pkg.sv ----
// package: control word layout, constants and types of the fieldbus control word decoder
package fbcwd_pkg;

   // ----------------------------------------------------------------
   // control word layout
   // ----------------------------------------------------------------
   // field order is msb first, so bit 15 is the reserved bit
   typedef struct packed {
      logic reserved;       // b15, ignored
      logic vin_c;          // b14, bus_virtual_input_c
      logic vin_b;          // b13, bus_virtual_input_b
      logic vin_a;          // b12, bus_virtual_input_a
      logic watchdog;       // b11, alive toggle
      logic bus_ctrl;       // b10, fieldbus control
      logic ref_sel_high;   // b09, voltage_ref_select_high
      logic ref_sel_low;    // b08, voltage_ref_select_low
      logic fault_reset;    // b07, acts on rising edge
      logic power_full;     // b06, extended: 0 = limited power
      logic droop_first;    // b05, extended: 1 = first droop setting
      logic float_disable;  // b04, extended: 0 = floating reference on
      logic run;            // b03, start on rising edge
      logic restart_ok;     // b02, extended: 0 = forced restart
      logic breaker_en;     // b01, extended: breaker close enable
      logic charge;         // b00, dc charge / open breaker
   } fbcwd_cw_s;

   localparam logic [15:0] FBCWD_CW_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // profile and control place codes
   // ----------------------------------------------------------------
   localparam logic [1:0] FBCWD_PROFILE_GEN = 2'h2;
   localparam logic [1:0] FBCWD_PROFILE_EXT = 2'h3;
   localparam logic [1:0] FBCWD_PLACE_BUS = 2'h3;

   // ----------------------------------------------------------------
   // voltage reference values, in hundredths of a percent
   // ----------------------------------------------------------------
   localparam logic [15:0] FBCWD_REF_110 = 16'h2AF8;   // 110.00 %
   localparam logic [15:0] FBCWD_REF_115 = 16'h2CEC;   // 115.00 %
   localparam logic [15:0] FBCWD_REF_120 = 16'h2EE0;   // 120.00 %
   localparam logic [15:0] FBCWD_REF_THRESHOLD = 16'h1388;   // 50.00 %
   localparam logic [15:0] FBCWD_POWER_LIMITED = 16'h01F4;   // 5.00 %

   typedef enum logic [3:0] {
      FBCWD_REFSRC_BUS = 4'b0001,
      FBCWD_REFSRC_110 = 4'b0010,
      FBCWD_REFSRC_115 = 4'b0100,
      FBCWD_REFSRC_120 = 4'b1000
   } fbcwd_refsrc_e;

   // ----------------------------------------------------------------
   // charge sequence states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      FBCWD_CH_IDLE = 3'b001,
      FBCWD_CH_PRECHARGE = 3'b010,
      FBCWD_CH_CLOSED = 3'b100
   } fbcwd_charge_e;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int FBCWD_CLK_MHZ = 100;
   localparam int FBCWD_WD_UNIT_US = 1000;   // watchdog delay counted in 1 ms steps
   localparam int FBCWD_CYCLES_PER_UNIT = FBCWD_WD_UNIT_US * FBCWD_CLK_MHZ;

   // ----------------------------------------------------------------
   // decoded outputs that travel together
   // ----------------------------------------------------------------
   typedef struct packed {
      logic breaker_close_enable;
      logic floating_ref_enable;
      logic droop_first;
      logic power_limited;
   } fbcwd_ext_s;

endpackage : fbcwd_pkg

// ---- fbcwd_decoder.sv ----
// fieldbus control word decoder for the generator and extended profiles only, no front_end_converter profile code
module fbcwd_decoder
   import fbcwd_pkg::*;
#(
   parameter int CYCLES_PER_UNIT = FBCWD_CYCLES_PER_UNIT  // clock cycles per watchdog delay step
) (
   input wire logic clk,                              // control clock, 100 MHz
   input wire logic reset_n,                          // synchronous reset, active low
   input wire logic [15:0] bus_control_word,          // control word from the master
   input wire logic bus_control_word_wr,              // one-cycle strobe, word valid
   input wire logic [1:0] control_profile_select,     // profile select parameter
   input wire logic [1:0] control_place,              // active control place code
   input wire logic precharge_do_enable,              // precharge function enabled on output
   input wire logic start_cmd,                        // ordinary start command, level
   input wire logic dc_charged,                       // dc link reached charge level
   input wire logic dc_link_zero,                     // dc link discharged to zero
   input wire logic drive_running,                    // drive is modulating
   input wire logic [15:0] bus_reference,             // bus dc reference, 0.01 %
   input wire logic [15:0] local_voltage_reference,   // local parameter reference, 0.01 %
   input wire logic [15:0] power_limit_param,         // parameterised power limit, 0.01 %
   input wire logic [15:0] link_alive_timeout_param,  // watchdog delay in steps, 0 = off
   output logic precharge_close,                      // precharge contactor command
   output logic main_breaker_close,                   // main_breaker close command
   output logic run_request,                          // run request level
   output logic start_pulse,                          // one-cycle start event
   output logic fault_reset_pulse,                    // one-cycle fault reset event
   output logic stop_normal,                          // one-cycle normal stop event
   output logic stop_coast,                           // one-cycle coasting stop event
   output logic bus_control_active,                   // control word is being obeyed
   output fbcwd_refsrc_e voltage_ref_source,          // selected reference source
   output logic [15:0] voltage_reference,             // resolved dc reference, 0.01 %
   output logic [15:0] power_limit,                   // resolved power limit, 0.01 %
   output fbcwd_ext_s ext_ctrl,                       // extended profile decodes
   output logic link_alive_fault,                     // watchdog fault, sticky
   output logic status_watchdog_echo,                 // status word bit 15
   output logic bus_virtual_input_a,                  // virtual input a
   output logic bus_virtual_input_b,                  // virtual input b
   output logic bus_virtual_input_c                   // virtual input c
);

   // ----------------------------------------------------------------
   // control word register and edge history
   // ----------------------------------------------------------------
   fbcwd_cw_s cw_q, cw_d, prev_q, prev_d;
   logic active_q, active_d;
   logic profile_ok, is_ext, bus_place;

   // profile check and word gating
   assign is_ext = (control_profile_select == FBCWD_PROFILE_EXT);
   assign profile_ok = (control_profile_select == FBCWD_PROFILE_GEN) || is_ext;
   assign bus_place = (control_place == FBCWD_PLACE_BUS);

   // word capture; history follows every cycle so edges last one cycle
   always_comb begin
      cw_d = cw_q;
      if (bus_control_word_wr) begin
         cw_d = fbcwd_cw_s'(bus_control_word);
      end
      prev_d = cw_q;
      active_d = profile_ok && cw_q.bus_ctrl;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cw_q <= fbcwd_cw_s'(FBCWD_CW_RESET);
         prev_q <= fbcwd_cw_s'(FBCWD_CW_RESET);
         active_q <= 1'b0;
      end else begin
         cw_q <= cw_d;
         prev_q <= prev_d;
         active_q <= active_d;
      end
   end

   // ----------------------------------------------------------------
   // run, start, reset and stop events
   // ----------------------------------------------------------------
   logic run_q, run_d, start_q, start_d, freset_q, freset_d;
   logic stopn_q, stopn_d, stopc_q, stopc_d;
   logic active_now;

   assign active_now = profile_ok && cw_q.bus_ctrl;

   // edges are only honoured while the word is obeyed
   always_comb begin
      run_d = run_q;
      start_d = 1'b0;
      freset_d = 1'b0;
      stopn_d = 1'b0;
      stopc_d = 1'b0;
      if (active_now && cw_q.run && !prev_q.run) begin
         start_d = 1'b1;
         run_d = 1'b1;
      end
      if (active_now && !cw_q.run) begin
         run_d = 1'b0;
      end
      if (active_now && cw_q.fault_reset && !prev_q.fault_reset) begin
         freset_d = 1'b1;
      end
      if (active_q && !active_now) begin
         run_d = 1'b0;
         if (drive_running && is_ext) begin
            stopc_d = 1'b1;
         end else if (drive_running) begin
            stopn_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         run_q <= 1'b0;
         start_q <= 1'b0;
         freset_q <= 1'b0;
         stopn_q <= 1'b0;
         stopc_q <= 1'b0;
      end else begin
         run_q <= run_d;
         start_q <= start_d;
         freset_q <= freset_d;
         stopn_q <= stopn_d;
         stopc_q <= stopc_d;
      end
   end

   // ----------------------------------------------------------------
   // precharge and main breaker sequence
   // ----------------------------------------------------------------
   fbcwd_charge_e ch_q, ch_d;
   logic charge_req, close_ok, restart_ok;

   // request source depends on the control place
   assign charge_req = precharge_do_enable &&
                       (bus_place ? (active_now && cw_q.charge) : start_cmd);
   assign close_ok = !(is_ext && bus_place) || cw_q.breaker_en;
   assign restart_ok = !(is_ext && bus_place) || cw_q.restart_ok || dc_link_zero;

   always_comb begin
      ch_d = ch_q;
      unique case (ch_q)
         FBCWD_CH_IDLE: begin
            if (charge_req && restart_ok) begin
               ch_d = FBCWD_CH_PRECHARGE;
            end
         end
         FBCWD_CH_PRECHARGE: begin
            if (!charge_req) begin
               ch_d = FBCWD_CH_IDLE;
            end else if (dc_charged && close_ok) begin
               ch_d = FBCWD_CH_CLOSED;
            end
         end
         FBCWD_CH_CLOSED: begin
            if (!charge_req) begin
               ch_d = FBCWD_CH_IDLE;
            end
         end
         default: begin
            ch_d = FBCWD_CH_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ch_q <= FBCWD_CH_IDLE;
      end else begin
         ch_q <= ch_d;
      end
   end

   // ----------------------------------------------------------------
   // reference, power limit and extended decodes
   // ----------------------------------------------------------------
   fbcwd_refsrc_e src_q, src_d;
   logic [15:0] vref_q, vref_d, plim_q, plim_d;
   fbcwd_ext_s ext_q, ext_d;
   logic [2:0] vin_q, vin_d;
   logic echo_q, echo_d;

   always_comb begin
      unique case ({cw_q.ref_sel_high, cw_q.ref_sel_low})
         2'b01: src_d = FBCWD_REFSRC_110;
         2'b10: src_d = FBCWD_REFSRC_115;
         2'b11: src_d = FBCWD_REFSRC_120;
         default: src_d = FBCWD_REFSRC_BUS;
      endcase
      if (!active_now) begin
         src_d = FBCWD_REFSRC_BUS;
      end
      unique case (src_d)
         FBCWD_REFSRC_110: vref_d = FBCWD_REF_110;
         FBCWD_REFSRC_115: vref_d = FBCWD_REF_115;
         FBCWD_REFSRC_120: vref_d = FBCWD_REF_120;
         default: begin
            if (active_now && bus_reference > FBCWD_REF_THRESHOLD) begin
               vref_d = bus_reference;
            end else begin
               vref_d = local_voltage_reference;
            end
         end
      endcase
      // generator profile leaves the extended bits at their neutral values
      ext_d.breaker_close_enable = !is_ext || cw_q.breaker_en;
      ext_d.floating_ref_enable = is_ext && !cw_q.float_disable;
      ext_d.droop_first = !is_ext || cw_q.droop_first;
      ext_d.power_limited = is_ext && !cw_q.power_full;
      plim_d = ext_d.power_limited ? FBCWD_POWER_LIMITED : power_limit_param;
      vin_d = active_now ? {cw_q.vin_c, cw_q.vin_b, cw_q.vin_a} : vin_q;
      echo_d = cw_q.watchdog;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         src_q <= FBCWD_REFSRC_BUS;
         vref_q <= 16'h0000;
         plim_q <= 16'h0000;
         ext_q <= '0;
         vin_q <= 3'h0;
         echo_q <= 1'b0;
      end else begin
         src_q <= src_d;
         vref_q <= vref_d;
         plim_q <= plim_d;
         ext_q <= ext_d;
         vin_q <= vin_d;
         echo_q <= echo_d;
      end
   end

   // ----------------------------------------------------------------
   // link alive watchdog
   // ----------------------------------------------------------------
   logic [31:0] pre_q, pre_d;
   logic [15:0] wd_q, wd_d;
   logic wdf_q, wdf_d;
   logic toggled, wd_on;

   assign toggled = cw_q.watchdog != prev_q.watchdog;
   assign wd_on = (link_alive_timeout_param != 16'h0000) && profile_ok;

   // a toggle restarts the count; the fault set wins over a reset event
   always_comb begin
      pre_d = pre_q;
      wd_d = wd_q;
      wdf_d = wdf_q;
      if (!wd_on || toggled) begin
         pre_d = 32'h0000_0000;
         wd_d = 16'h0000;
      end else if (pre_q == 32'(CYCLES_PER_UNIT - 1)) begin
         pre_d = 32'h0000_0000;
         if (wd_q != 16'hFFFF) begin
            wd_d = wd_q + 16'h0001;
         end
      end else begin
         pre_d = pre_q + 32'h0000_0001;
      end
      if (freset_q) begin
         wdf_d = 1'b0;
      end
      if (wd_on && wd_q >= link_alive_timeout_param) begin
         wdf_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pre_q <= 32'h0000_0000;
         wd_q <= 16'h0000;
         wdf_q <= 1'b0;
      end else begin
         pre_q <= pre_d;
         wd_q <= wd_d;
         wdf_q <= wdf_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign {main_breaker_close, precharge_close} = {ch_q == FBCWD_CH_CLOSED, ch_q == FBCWD_CH_PRECHARGE};
   assign run_request = run_q;
   assign {start_pulse, fault_reset_pulse} = {start_q, freset_q};
   assign {stop_normal, stop_coast} = {stopn_q, stopc_q};
   assign bus_control_active = active_q;
   assign voltage_ref_source = src_q;
   assign voltage_reference = vref_q;
   assign power_limit = plim_q;
   assign ext_ctrl = ext_q;
   assign link_alive_fault = wdf_q;
   assign status_watchdog_echo = echo_q;
   assign {bus_virtual_input_c, bus_virtual_input_b, bus_virtual_input_a} = vin_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_run_rise;
      active_now && cw_q.run && !prev_q.run;
   endsequence
   sequence s_ctrl_drop;
      active_q && !active_now && drive_running;
   endsequence
   a_start_on_edge: assert property (@(posedge clk) disable iff (!reset_n)
      s_run_rise |=> start_pulse && run_request)
      else $error("start edge not turned into start pulse");
   a_start_needs_edge: assert property (@(posedge clk) disable iff (!reset_n)
      start_pulse |-> $past(cw_q.run) && !$past(prev_q.run))
      else $error("start pulse without rising run bit");
   a_reset_edge_only: assert property (@(posedge clk) disable iff (!reset_n)
      fault_reset_pulse |-> $past(active_now) && $past(cw_q.fault_reset) && !$past(prev_q.fault_reset))
      else $error("fault reset without rising edge");
   a_gen_stop_normal: assert property (@(posedge clk) disable iff (!reset_n)
      s_ctrl_drop ##0 !is_ext |=> stop_normal && !stop_coast && !run_request)
      else $error("generator profile did not stop normally");
   a_ext_stop_coast: assert property (@(posedge clk) disable iff (!reset_n)
      s_ctrl_drop ##0 is_ext |=> stop_coast && !stop_normal)
      else $error("extended profile did not coast");
   a_open_breaker: assert property (@(posedge clk) disable iff (!reset_n)
      (main_breaker_close || precharge_close) && !charge_req |=> !main_breaker_close && !precharge_close)
      else $error("breaker or precharge held without charge request");
   a_breaker_enable: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(main_breaker_close) && is_ext && bus_place |-> $past(cw_q.breaker_en))
      else $error("breaker closed while close enable low");
   a_ref_select: assert property (@(posedge clk) disable iff (!reset_n)
      active_now && cw_q.ref_sel_low && cw_q.ref_sel_high |=> voltage_reference == FBCWD_REF_120)
      else $error("both select bits high did not give 120 percent");
   a_ref_fallback: assert property (@(posedge clk) disable iff (!reset_n)
      !active_now |=> voltage_reference == $past(local_voltage_reference))
      else $error("local reference not used without bus control");
   a_wd_disabled: assert property (@(posedge clk) disable iff (!reset_n)
      link_alive_timeout_param == 16'h0000 && !link_alive_fault ##1 link_alive_timeout_param == 16'h0000
      |-> !link_alive_fault)
      else $error("watchdog fault with supervision disabled");
   a_wd_echo: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 status_watchdog_echo == $past(cw_q.watchdog))
      else $error("watchdog bit not echoed");
   a_power_limit: assert property (@(posedge clk) disable iff (!reset_n)
      is_ext && !cw_q.power_full |=> power_limit == FBCWD_POWER_LIMITED)
      else $error("power not limited to 5 percent");

endmodule : fbcwd_decoder

// ---- fbcwd_master.sv ----
// partner model: fieldbus master that writes control words and toggles the alive bit
module fbcwd_master #(
   parameter int HALF_PERIOD = 8  // cycles per half wave of the alive toggle
) (
   input wire logic clk,                  // control clock
   input wire logic [15:0] cmd,           // word asked for by the bench
   input wire logic send,                 // write cmd once
   input wire logic wd_run,               // keep the alive toggle going
   output logic [15:0] bus_control_word,  // word to the decoder
   output logic bus_control_word_wr       // write strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wd_q = 1'b0;
   logic [15:0] last_q = 16'h0000;
   int cnt = 0;
   logic fire;
   // write after the falling edge; between writes the lines carry the inverse, not a held word
   always @(negedge clk) begin
      fire = send;
      if (wd_run && cnt >= HALF_PERIOD - 1) begin
         wd_q = ~wd_q;
         cnt = 0;
         fire = 1'b1;
      end else if (wd_run) begin
         cnt++;
      end
      bus_control_word_wr <= fire;
      if (fire) begin
         last_q = {cmd[15:12], wd_q, cmd[10:0]};
         bus_control_word <= last_q;
      end else begin
         bus_control_word <= ~last_q;
      end
   end
endmodule : fbcwd_master

// ---- fbcwd_decoder_bench.sv ----
// testbench: self-checking run of the fieldbus control word decoder
module fbcwd_decoder_bench import fbcwd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, reset_n = 0, send = 0, wd_run = 0, wr;
   logic [15:0] cmd = 16'h0000, word;
   logic [1:0] profile = 2'h2, place = 2'h3;
   logic do_en = 1, start_cmd = 0, dc_chg = 0, dc_zero = 0, running = 0;
   logic [15:0] bus_ref = 16'h1770, loc_ref = 16'h2328, plim_p = 16'h0BB8, wd_delay = 16'h0000;
   logic pre_c, main_c, run_req, st_p, fr_p, stop_n, stop_c, active, wd_fault, echo, vin_a, vin_b, vin_c;
   fbcwd_refsrc_e src;
   logic [15:0] vref, plim;
   fbcwd_ext_s ext;
   int fails = 0, checks = 0, n_st = 0, n_fr = 0, n_sn = 0, n_sc = 0;
   logic [3:0] src_t[4] = '{4'b0001, 4'b0010, 4'b0100, 4'b1000};
   logic [15:0] ref_t[4];

   fbcwd_master #(.HALF_PERIOD(8)) mst (.clk(clk), .cmd(cmd), .send(send), .wd_run(wd_run),
      .bus_control_word(word), .bus_control_word_wr(wr));
   fbcwd_decoder #(.CYCLES_PER_UNIT(4)) dut (.clk(clk), .reset_n(reset_n), .bus_control_word(word),
      .bus_control_word_wr(wr), .control_profile_select(profile), .control_place(place),
      .precharge_do_enable(do_en), .start_cmd(start_cmd), .dc_charged(dc_chg), .dc_link_zero(dc_zero),
      .drive_running(running), .bus_reference(bus_ref), .local_voltage_reference(loc_ref),
      .power_limit_param(plim_p), .link_alive_timeout_param(wd_delay), .precharge_close(pre_c),
      .main_breaker_close(main_c), .run_request(run_req), .start_pulse(st_p), .fault_reset_pulse(fr_p),
      .stop_normal(stop_n), .stop_coast(stop_c), .bus_control_active(active), .voltage_ref_source(src),
      .voltage_reference(vref), .power_limit(plim), .ext_ctrl(ext), .link_alive_fault(wd_fault),
      .status_watchdog_echo(echo), .bus_virtual_input_a(vin_a), .bus_virtual_input_b(vin_b),
      .bus_virtual_input_c(vin_c));

   always #5 clk = ~clk;
   // count the one-cycle events mid-cycle, away from the edge that launches them
   always @(negedge clk) begin
      if (st_p === 1'b1) n_st++;
      if (fr_p === 1'b1) n_fr++;
      if (stop_n === 1'b1) n_sn++;
      if (stop_c === 1'b1) n_sc++;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task chk1(input logic a, input logic e);
      checks++;
      if (a !== e) begin
         fails++;
         $display("[FAIL] %0t bit %b expected %b", $time, a, e);
      end
   endtask : chk1
   task chk16(input logic [15:0] a, input logic [15:0] e);
      checks++;
      if (a !== e) begin
         fails++;
         $display("[FAIL] %0t value %h expected %h", $time, a, e);
      end
   endtask : chk16
   // one write through the master, then time for the registered answer to settle
   task put(input logic [15:0] w);
      @(negedge clk);
      cmd <= w;
      send <= 1'b1;
      @(negedge clk);
      send <= 1'b0;
      repeat (5) @(negedge clk);
   endtask : put
   task wrap_up;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task sc_run;
      put(16'h0008);
      chk16(16'(n_st), 16'h0000);
      put(16'h0400);
      put(16'h0408);
      chk16(16'(n_st), 16'h0001);
      chk1(run_req, 1'b1);
      put(16'h0408);
      chk16(16'(n_st), 16'h0001);
      put(16'h0400);
      chk1(run_req, 1'b0);
      put(16'h0480);
      put(16'h0480);
      chk16(16'(n_fr), 16'h0001);
   endtask : sc_run
   task sc_ref;
      ref_t = '{bus_ref, FBCWD_REF_110, FBCWD_REF_115, FBCWD_REF_120};
      for (int s = 0; s < 4; s++) begin
         put(16'h0400 | 16'(s << 8));
         chk16(16'(src), 16'(src_t[s]));
         chk16(vref, ref_t[s]);
      end
      bus_ref <= 16'h0FA0;
      put(16'h0400);
      chk16(vref, loc_ref);
      bus_ref <= 16'h1770;
      put(16'h0000);
      chk16(vref, loc_ref);
   endtask : sc_ref
   task sc_charge;
      put(16'h0401);
      chk1(pre_c, 1'b1);
      dc_chg <= 1'b1;
      repeat (4) @(negedge clk);
      chk1(main_c, 1'b1);
      put(16'h0400);
      chk1(main_c, 1'b0);
      dc_chg <= 1'b0;
      put(16'h0401);
      put(16'h0400);
      chk1(pre_c, 1'b0);
      place <= 2'h1;
      start_cmd <= 1'b1;
      repeat (4) @(negedge clk);
      chk1(pre_c, 1'b1);
      start_cmd <= 1'b0;
      place <= 2'h3;
      put(16'h0000);
   endtask : sc_charge
   task sc_drop;
      running <= 1'b1;
      put(16'h0408);
      put(16'h0000);
      chk16(16'(n_sn), 16'h0001);
      profile <= 2'h3;
      put(16'h0408);
      put(16'h0000);
      chk16(16'(n_sc), 16'h0001);
      running <= 1'b0;
   endtask : sc_drop
   task sc_ext;
      put(16'h0400);
      chk16(16'(ext), 16'h0005);
      chk16(plim, FBCWD_POWER_LIMITED);
      put(16'h0472);
      chk16(16'(ext), 16'h000A);
      chk16(plim, plim_p);
      put(16'h0401);
      chk1(pre_c, 1'b0);
      put(16'h0405);
      chk1(pre_c, 1'b1);
      dc_chg <= 1'b1;
      repeat (4) @(negedge clk);
      chk1(main_c, 1'b0);
      put(16'h0407);
      chk1(main_c, 1'b1);
      dc_chg <= 1'b0;
      put(16'h0400);
      profile <= 2'h2;
      put(16'h0400);
      chk16(16'(ext), 16'h000A);
      chk1(active, 1'b1);
   endtask : sc_ext
   task sc_watchdog;
      int i;
      wd_delay <= 16'h0003;
      wd_run <= 1'b1;
      repeat (60) @(negedge clk);
      chk1(wd_fault, 1'b0);
      wd_run <= 1'b0;
      for (i = 0; i < 40 && wd_fault !== 1'b1; i++) @(negedge clk);
      chk1(wd_fault, 1'b1);
      chk1(echo, mst.wd_q);
      wd_delay <= 16'h0000;
      put(16'h0480);
      repeat (40) @(negedge clk);
      chk1(wd_fault, 1'b0);
      put(16'hF400);
      chk16({13'h0000, vin_c, vin_b, vin_a}, 16'h0007);
      chk1(run_req, 1'b0);
   endtask : sc_watchdog

   // reset, then every scenario in turn
   initial begin
      repeat (5) @(negedge clk);
      reset_n <= 1'b1;
      chk16(16'(src), 16'h0001);
      sc_run();
      sc_ref();
      sc_charge();
      sc_drop();
      sc_ext();
      sc_watchdog();
      wrap_up();
   end
endmodule : fbcwd_decoder_bench
